// ### logic/dsd_data_space_decoder.sv
// Data space decoder: program memory, working registers, I/O steering and SRAM.
`timescale 1ns/1ps
`include "dsd_defines.svh"

module dsd_data_space_decoder (
  // Clock and reset.
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Instruction fetch.
  input  wire logic [11:0]        fetch_ip,
  output logic      [15:0]        fetch_data_r,
  // Program memory loading.
  input  wire logic               prog_we,
  input  wire logic [11:0]        prog_waddr,
  input  wire logic [15:0]        prog_wdata,
  // Data request and answer.
  input  wire dsd_pkg::dsd_req_t  req,
  output logic                    busy_r,
  output dsd_pkg::dsd_resp_t      resp_r,
  // Peripheral register strobe.
  output dsd_pkg::dsd_io_t        io_r,
  input  wire logic [7:0]         io_rdata
);

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  logic [15:0] prog_mem [`DSD_PROG_WORDS];   // Instruction words.
  logic [7:0]  wreg     [`DSD_WREG_WORDS];   // Working register file.
  logic [7:0]  sram     [`DSD_SRAM_WORDS];   // Internal data memory.
  logic [7:0]  scratch_r [3];                // Bit-addressable scratch stores.

  typedef enum {ST_IDLE, ST_IO_WAIT, ST_BIT_WR, ST_SRAM2} dsd_state_t;
  dsd_state_t state_r;                       // Sequencer state.
  dsd_pkg::dsd_req_t req_r;                  // Request held while pending.
  logic [8:0]  sram_addr_r;                  // Latched SRAM word index.
  logic [15:0] last_addr_r;                  // Last resolved data address.

  // Region lookup; used for the request and for the assertions.
  function automatic dsd_pkg::dsd_region_t region_of(input logic [15:0] a);
    if (a <= `DSD_WREG_LAST)       region_of = dsd_pkg::DSD_RGN_WREG;
    else if (a <= `DSD_STDIO_LAST) region_of = dsd_pkg::DSD_RGN_STDIO;
    else if (a <= `DSD_EXTIO_LAST) region_of = dsd_pkg::DSD_RGN_EXTIO;
    else if (a <= `DSD_SRAM_LAST)  region_of = dsd_pkg::DSD_RGN_SRAM;
    else                           region_of = dsd_pkg::DSD_RGN_NONE;
  endfunction

  // Scratch index for a short address, 3 when none matches.
  function automatic logic [1:0] scratch_of(input logic [5:0] s);
    case (s)
      `DSD_SCRATCH0_SHORT: scratch_of = 2'h0;
      `DSD_SCRATCH1_SHORT: scratch_of = 2'h1;
      `DSD_SCRATCH2_SHORT: scratch_of = 2'h2;
      default:             scratch_of = 2'h3;
    endcase
  endfunction

  // Bit operation result on an old byte.
  function automatic logic [7:0] bit_apply(input logic [7:0] old,
                                           input dsd_pkg::dsd_mode_t m,
                                           input logic [2:0] b);
    logic [7:0] mask;
    mask = 8'h01 << b;
    if (m == dsd_pkg::DSD_IO_BIT_SET)      bit_apply = old | mask;
    else if (m == dsd_pkg::DSD_IO_BIT_CLR) bit_apply = old & ~mask;
    else                                   bit_apply = old;
  endfunction

  // ----------------------------------------------------------------------------
  // Address formation
  // ----------------------------------------------------------------------------
  logic [4:0]  ptr_lo;       // Low register of the chosen pointer pair.
  logic [15:0] ptr_c;        // Current pointer value.
  logic [15:0] ptr_new_c;    // Value written back after the access.
  logic        ptr_upd_c;    // Pointer is written back.
  logic [15:0] addr_c;       // Resolved data address.
  logic        is_short_c;   // Request uses a short I/O address.
  logic        is_bit_c;     // Request is a bit operation.
  logic        refuse_c;     // Request is rejected.
  logic        take_c;       // Request taken this cycle.
  dsd_pkg::dsd_region_t rgn_c;
  logic [1:0]  scr_c;        // Scratch store hit.
  logic [7:0]  old_c;        // Byte read from an internal region.

  always_comb begin
    ptr_lo = (req.ptr_sel == dsd_pkg::DSD_PTR_X) ? `DSD_PTR_X_LO :
             (req.ptr_sel == dsd_pkg::DSD_PTR_Y) ? `DSD_PTR_Y_LO : `DSD_PTR_Z_LO;
    ptr_c = {wreg[ptr_lo + 5'h1], wreg[ptr_lo]};
    is_short_c = req.mode inside {dsd_pkg::DSD_IO_SHORT, dsd_pkg::DSD_IO_BIT_SET,
                                  dsd_pkg::DSD_IO_BIT_CLR, dsd_pkg::DSD_IO_BIT_TEST};
    is_bit_c = is_short_c && (req.mode != dsd_pkg::DSD_IO_SHORT);
    ptr_upd_c = 1'b0;
    ptr_new_c = ptr_c;
    case (req.mode)
      dsd_pkg::DSD_DIRECT:    addr_c = req.addr;
      dsd_pkg::DSD_INDIRECT:  addr_c = ptr_c;
      dsd_pkg::DSD_DISPLACED: addr_c = ptr_c + {10'h000, req.disp};
      dsd_pkg::DSD_PREDEC: begin
        addr_c = ptr_c - 16'h0001;
        ptr_new_c = ptr_c - 16'h0001;
        ptr_upd_c = 1'b1;
      end
      dsd_pkg::DSD_POSTINC: begin
        addr_c = ptr_c;
        ptr_new_c = ptr_c + 16'h0001;
        ptr_upd_c = 1'b1;
      end
      default: addr_c = {10'h000, req.addr[5:0]} + `DSD_SHORT_OFFSET;
    endcase
    // Bit operations above the bit range and displacement off X are refused.
    refuse_c = (is_bit_c && (req.addr[5:0] > `DSD_BIT_IO_LAST)) ||
               (req.mode == dsd_pkg::DSD_DISPLACED && req.ptr_sel == dsd_pkg::DSD_PTR_X);
    take_c = req.valid && (state_r == ST_IDLE);
    rgn_c = region_of(addr_c);
    scr_c = (rgn_c == dsd_pkg::DSD_RGN_STDIO) ? scratch_of(addr_c[5:0] - 6'h20) : 2'h3;
    if (rgn_c == dsd_pkg::DSD_RGN_WREG) old_c = wreg[addr_c[4:0]];
    else if (scr_c != 2'h3)             old_c = scratch_r[scr_c];
    else                                old_c = 8'h00;
  end

  // Request goes out to the peripheral file (standard or extended I/O).
  logic to_io_c;
  logic to_sram_c;
  assign to_io_c = take_c && !refuse_c && scr_c == 2'h3 &&
                   (rgn_c inside {dsd_pkg::DSD_RGN_STDIO, dsd_pkg::DSD_RGN_EXTIO});
  assign to_sram_c = take_c && !refuse_c && rgn_c == dsd_pkg::DSD_RGN_SRAM;

  // ----------------------------------------------------------------------------
  // Program memory: load port and registered fetch
  // ----------------------------------------------------------------------------
  // A fetch returns the addressed word one cycle later.
  always_ff @(posedge clk_sys) begin
    if (prog_we) prog_mem[prog_waddr] <= prog_wdata;
    fetch_data_r <= prog_mem[fetch_ip];
  end

  // ----------------------------------------------------------------------------
  // Working registers: data writes, then pointer write-back
  // ----------------------------------------------------------------------------
  // The pointer write-back is placed last so it wins if the access hits the pair.
  always_ff @(posedge clk_sys) begin
    if (take_c && !refuse_c && req.write && rgn_c == dsd_pkg::DSD_RGN_WREG)
      wreg[addr_c[4:0]] <= req.wdata;
    if (take_c && !refuse_c && ptr_upd_c) begin
      wreg[ptr_lo]        <= ptr_new_c[7:0];
      wreg[ptr_lo + 5'h1] <= ptr_new_c[15:8];
    end
  end

  // ----------------------------------------------------------------------------
  // Scratch stores
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) scratch_r[i] <= `DSD_SCRATCH_RESET;
    end else if (take_c && !refuse_c && scr_c != 2'h3) begin
      if (is_bit_c)        scratch_r[scr_c] <= bit_apply(old_c, req.mode, req.bit_idx);
      else if (req.write)  scratch_r[scr_c] <= req.wdata;
    end
  end

  // ----------------------------------------------------------------------------
  // SRAM: address latched on take, array touched on the second edge
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (to_sram_c) sram_addr_r <= addr_c[8:0] - 9'h100;
    if (state_r == ST_SRAM2 && req_r.write) sram[sram_addr_r] <= req_r.wdata;
  end

  // ----------------------------------------------------------------------------
  // Sequencer and answer
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      req_r       <= '0;
      resp_r      <= '0;
      busy_r      <= 1'b0;
      last_addr_r <= 16'h0000;
    end else begin
      resp_r.valid <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (take_c) begin
            req_r       <= req;
            last_addr_r <= addr_c;
            resp_r.err  <= refuse_c;
            if (refuse_c) begin
              resp_r.valid <= 1'b1;
              resp_r.rdata <= 8'h00;
            end else if (to_sram_c) begin
              state_r <= ST_SRAM2;
              busy_r  <= 1'b1;
            end else if (to_io_c) begin
              state_r <= ST_IO_WAIT;
              busy_r  <= 1'b1;
            end else begin
              // Internal regions and the unmapped range answer at once.
              resp_r.valid   <= 1'b1;
              resp_r.rdata   <= old_c;
              resp_r.bit_val <= old_c[req.bit_idx];
            end
          end
        end
        ST_IO_WAIT: begin
          resp_r.rdata   <= io_rdata;
          resp_r.bit_val <= io_rdata[req_r.bit_idx];
          if (req_r.mode inside {dsd_pkg::DSD_IO_BIT_SET, dsd_pkg::DSD_IO_BIT_CLR}) begin
            state_r <= ST_BIT_WR;
          end else begin
            resp_r.valid <= 1'b1;
            busy_r       <= 1'b0;
            state_r      <= ST_IDLE;
          end
        end
        ST_BIT_WR: begin
          resp_r.valid <= 1'b1;
          busy_r       <= 1'b0;
          state_r      <= ST_IDLE;
        end
        ST_SRAM2: begin
          resp_r.valid <= 1'b1;
          resp_r.rdata <= sram[sram_addr_r];
          busy_r       <= 1'b0;
          state_r      <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Peripheral strobe
  // ----------------------------------------------------------------------------
  // Bit set and clear on a peripheral register are read, then written back.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      io_r <= '0;
    end else begin
      io_r.sel <= 1'b0;
      if (to_io_c) begin
        io_r.sel   <= 1'b1;
        io_r.write <= req.write && !is_bit_c;
        io_r.addr  <= addr_c[7:0];
        io_r.wdata <= req.wdata;
      end else if (state_r == ST_IO_WAIT && req_r.mode inside
                   {dsd_pkg::DSD_IO_BIT_SET, dsd_pkg::DSD_IO_BIT_CLR}) begin
        io_r.sel   <= 1'b1;
        io_r.write <= 1'b1;
        io_r.wdata <= bit_apply(io_rdata, req_r.mode, req_r.bit_idx);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  property p_sram_two;
    @(posedge clk_sys) disable iff (rst) to_sram_c |=> !resp_r.valid ##1 resp_r.valid;
  endproperty
  a_sram_two: assert property (p_sram_two) else $error("SRAM answer not on second edge");

  property p_none_zero;
    @(posedge clk_sys) disable iff (rst)
      take_c && !refuse_c && rgn_c == dsd_pkg::DSD_RGN_NONE |=>
      resp_r.valid && resp_r.rdata == 8'h00 && !io_r.sel;
  endproperty
  a_none_zero: assert property (p_none_zero) else $error("Unmapped access not zero");

  property p_bit_range;
    @(posedge clk_sys) disable iff (rst)
      take_c && is_bit_c && req.addr[5:0] > 6'h1F |=> resp_r.valid && resp_r.err;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("High bit operation accepted");

  property p_predec;
    @(posedge clk_sys) disable iff (rst)
      take_c && req.mode == dsd_pkg::DSD_PREDEC |=> last_addr_r == $past(ptr_c) - 16'h0001;
  endproperty
  a_predec: assert property (p_predec) else $error("Pre-decrement address wrong");

  property p_postinc;
    @(posedge clk_sys) disable iff (rst)
      take_c && req.mode == dsd_pkg::DSD_POSTINC |=> last_addr_r == $past(ptr_c);
  endproperty
  a_postinc: assert property (p_postinc) else $error("Post-increment address wrong");

  property p_short_map;
    @(posedge clk_sys) disable iff (rst)
      to_io_c && is_short_c |=> io_r.sel && io_r.addr == {2'h0, $past(req.addr[5:0])} + 8'h20;
  endproperty
  a_short_map: assert property (p_short_map) else $error("Short address offset wrong");

  property p_short_no_ext;
    @(posedge clk_sys) disable iff (rst)
      take_c && is_short_c |=> !(io_r.sel && io_r.addr > 8'h5F);
  endproperty
  a_short_no_ext: assert property (p_short_no_ext) else $error("Short access hit extended I/O");

  property p_wreg_fast;
    @(posedge clk_sys) disable iff (rst)
      take_c && !refuse_c && rgn_c == dsd_pkg::DSD_RGN_WREG |=> resp_r.valid && !busy_r;
  endproperty
  a_wreg_fast: assert property (p_wreg_fast) else $error("Working register access slow");

  c_sram:   cover property (@(posedge clk_sys) disable iff (rst) to_sram_c ##2 resp_r.valid);
  c_predec: cover property (@(posedge clk_sys) disable iff (rst)
                            take_c && req.mode == dsd_pkg::DSD_PREDEC);
  c_io_bit: cover property (@(posedge clk_sys) disable iff (rst)
                            to_io_c && req.mode == dsd_pkg::DSD_IO_BIT_SET ##3 resp_r.valid);

endmodule // dsd_data_space_decoder

// ### include/dsd_defines.svh
// Address map, field positions and timing counts of the data space decoder.
`ifndef DSD_DEFINES_SVH
`define DSD_DEFINES_SVH

// ----------------------------------------------------------------------------
// Program memory
// ----------------------------------------------------------------------------
`define DSD_PROG_WORDS     4096
`define DSD_PROG_LAST      12'hFFF
`define DSD_IP_W           12

// ----------------------------------------------------------------------------
// Unified data space regions
// ----------------------------------------------------------------------------
`define DSD_WREG_BASE      16'h0000
`define DSD_WREG_LAST      16'h001F
`define DSD_STDIO_BASE     16'h0020
`define DSD_STDIO_LAST     16'h005F
`define DSD_EXTIO_BASE     16'h0060
`define DSD_EXTIO_LAST     16'h00FF
`define DSD_SRAM_BASE      16'h0100
`define DSD_SRAM_LAST      16'h02FF
`define DSD_WREG_WORDS     32
`define DSD_SRAM_WORDS     512

// ----------------------------------------------------------------------------
// Short I/O addressing
// ----------------------------------------------------------------------------
`define DSD_SHORT_OFFSET   16'h0020
`define DSD_BIT_IO_LAST    6'h1F
`define DSD_SCRATCH0_SHORT 6'h1C
`define DSD_SCRATCH1_SHORT 6'h1D
`define DSD_SCRATCH2_SHORT 6'h1E
`define DSD_SCRATCH_RESET  8'h00

// ----------------------------------------------------------------------------
// Pointer pairs (low byte index; high byte is the next register)
// ----------------------------------------------------------------------------
`define DSD_PTR_X_LO       5'h1A
`define DSD_PTR_Y_LO       5'h1C
`define DSD_PTR_Z_LO       5'h1E

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DSD_SRAM_CYCLES    2

`endif

// ### include/dsd_pkg.sv
// Types shared by the data space decoder and its users.
package dsd_pkg;

  // Access modes that the core may request.
  typedef enum logic [3:0] {
    DSD_DIRECT,
    DSD_INDIRECT,
    DSD_DISPLACED,
    DSD_PREDEC,
    DSD_POSTINC,
    DSD_IO_SHORT,
    DSD_IO_BIT_SET,
    DSD_IO_BIT_CLR,
    DSD_IO_BIT_TEST
  } dsd_mode_t;

  // Pointer pair selection.
  typedef enum logic [1:0] {
    DSD_PTR_X,
    DSD_PTR_Y,
    DSD_PTR_Z
  } dsd_ptr_t;

  // Region that a data address falls in.
  typedef enum logic [2:0] {
    DSD_RGN_WREG,
    DSD_RGN_STDIO,
    DSD_RGN_EXTIO,
    DSD_RGN_SRAM,
    DSD_RGN_NONE
  } dsd_region_t;

  // One data request from the core.
  typedef struct packed {
    logic      valid;
    logic      write;
    dsd_mode_t mode;
    logic [15:0] addr;
    dsd_ptr_t  ptr_sel;
    logic [5:0] disp;
    logic [2:0] bit_idx;
    logic [7:0] wdata;
  } dsd_req_t;

  // Answer to the core.
  typedef struct packed {
    logic        valid;
    logic        err;
    logic        bit_val;
    logic [7:0]  rdata;
  } dsd_resp_t;

  // Strobe towards the peripheral register file.
  typedef struct packed {
    logic       sel;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dsd_io_t;

endpackage

// ### testbench/dsd_periph_model.sv
// Peripheral register file model that answers the decoder's I/O strobe.
`timescale 1ns/1ps

module dsd_periph_model (
  // Clock.
  input  wire logic            clk_sys,
  // Strobe from the decoder and the read answer.
  input  wire dsd_pkg::dsd_io_t io,
  output logic [7:0]           rdata
);
  // Stored bytes are kept scrambled so that each place starts at addr ^ 0x5A.
  logic [7:0] regs [0:255] = '{default: 8'h00};
  // Last byte handed out, inverted while not selected.
  logic [7:0] last_r       = 8'h00;

  // ----------------------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------------------
  // A released bus shows the inverse of its last value, never a stale copy.
  always_comb begin
    if (io.sel) begin
      rdata = regs[io.addr] ^ io.addr ^ 8'h5A;
    end else begin
      rdata = ~last_r;
    end
  end

  // ----------------------------------------------------------------------------
  // Write and bus history
  // ----------------------------------------------------------------------------
  // Writes land on the edge where the strobe is high.
  always @(posedge clk_sys) begin
    if (io.sel) begin
      last_r <= rdata;
      if (io.write) begin
        regs[io.addr] <= io.wdata ^ io.addr ^ 8'h5A;
      end
    end
  end
endmodule // dsd_periph_model

// ### testbench/dsd_data_space_decoder_bench.sv
// Self-checking bench for the data space decoder.
`timescale 1ns/1ps

module dsd_data_space_decoder_bench;
  // ----------------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------------
  logic               clk_sys;
  logic               rst;
  logic [11:0]        fetch_ip;
  logic [15:0]        fetch_data_r;
  logic               prog_we;
  logic [11:0]        prog_waddr;
  logic [15:0]        prog_wdata;
  dsd_pkg::dsd_req_t  req;
  logic               busy_r;
  dsd_pkg::dsd_resp_t resp_r;
  dsd_pkg::dsd_io_t   io_r;
  logic [7:0]         io_rdata;
  logic [7:0]         io_last;      // Address of the last strobe seen.
  int                 n_mismatch;
  int                 num_checks;
  int                 lat;          // Edges from take to answer.
  logic               bsy;          // Busy seen just after the take edge.

  dsd_data_space_decoder i_dsd_data_space_decoder (
    .clk_sys(clk_sys), .rst(rst), .fetch_ip(fetch_ip),
    .fetch_data_r(fetch_data_r), .prog_we(prog_we), .prog_waddr(prog_waddr),
    .prog_wdata(prog_wdata), .req(req), .busy_r(busy_r), .resp_r(resp_r),
    .io_r(io_r), .io_rdata(io_rdata));

  dsd_periph_model i_dsd_periph_model (.clk_sys(clk_sys), .io(io_r), .rdata(io_rdata));

  // Free-running system clock at 20 MHz.
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Remember where the decoder last steered a peripheral access.
  always @(posedge clk_sys) begin
    if (io_r.sel === 1'h1) io_last <= io_r.addr;
  end

  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  // Compare one value and count it.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One request held until the take edge, then a bounded wait for the answer.
  task automatic acc(input logic w, input dsd_pkg::dsd_mode_t m, input logic [15:0] a,
                     input dsd_pkg::dsd_ptr_t p, input logic [5:0] d,
                     input logic [2:0] b, input logic [7:0] wd);
    @(posedge clk_sys);
    req <= '{valid: 1'h1, write: w, mode: m, addr: a, ptr_sel: p, disp: d,
             bit_idx: b, wdata: wd};
    @(posedge clk_sys);
    req.valid <= 1'h0;
    lat = 0;
    // Look just after each edge, the take edge first, so a one-cycle answer
    // is caught while it stands and its fields can still be judged.
    for (int i = 1; i <= 8 && lat == 0; i++) begin
      #1;
      if (i == 1) bsy = busy_r;
      if (resp_r.valid === 1'h1) lat = i;
      else @(posedge clk_sys);
    end
  endtask

  // Direct write and read of one data address.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    acc(1'h1, dsd_pkg::DSD_DIRECT, a, dsd_pkg::DSD_PTR_X, 6'h00, 3'h0, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input int l);
    acc(1'h0, dsd_pkg::DSD_DIRECT, a, dsd_pkg::DSD_PTR_X, 6'h00, 3'h0, 8'h00);
    chk("rdata", resp_r.rdata, e);
    chk("latency", lat, l);
    chk("busy", bsy, l > 1);
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  // Both ends of program memory hold and fetch a word.
  task automatic t_prog();
    @(posedge clk_sys);
    prog_we <= 1'h1;
    prog_waddr <= 12'hFFF;
    prog_wdata <= 16'hBEEF;
    @(posedge clk_sys);
    prog_waddr <= 12'h000;
    prog_wdata <= 16'h1234;
    @(posedge clk_sys);
    prog_we <= 1'h0;
    fetch_ip <= 12'hFFF;
    @(posedge clk_sys);
    #1 chk("fetch top", fetch_data_r, 16'hBEEF);
    @(posedge clk_sys);
    fetch_ip <= 12'h000;
    @(posedge clk_sys);
    #1 chk("fetch base", fetch_data_r, 16'h1234);
  endtask

  // Working registers answer in one edge, SRAM edges answer in two.
  task automatic t_regions();
    wr(16'h001F, 8'hC3);
    rd(16'h001F, 8'hC3, 1);
    wr(16'h0100, 8'h11);
    wr(16'h02FF, 8'h22);
    rd(16'h0100, 8'h11, 2);
    rd(16'h02FF, 8'h22, 2);
    wr(16'h0300, 8'h99);
    rd(16'h0300, 8'h00, 1);
    chk("unmapped err", resp_r.err, 1'h0);
  endtask

  // Short and long addresses meet at the same peripheral place.
  task automatic t_io();
    acc(1'h0, dsd_pkg::DSD_IO_SHORT, 16'h0001, dsd_pkg::DSD_PTR_X, 6'h00, 3'h0, 8'h00);
    chk("short read", resp_r.rdata, 8'h7B);
    chk("short addr", io_last, 8'h21);
    rd(16'h0021, 8'h7B, 2);
    rd(16'h0060, 8'h3A, 2);
    chk("ext addr", io_last, 8'h60);
    rd(16'h00FF, 8'hA5, 2);
    wr(16'h0070, 8'h4D);
    rd(16'h0070, 8'h4D, 2);
    chk("ext write addr", io_last, 8'h70);
  endtask

  // Bit operations on scratch and peripheral places, and a refused one.
  task automatic t_bits();
    rd(16'h003D, 8'h00, 1);
    acc(1'h1, dsd_pkg::DSD_IO_BIT_SET, 16'h001C, dsd_pkg::DSD_PTR_X, 6'h00, 3'h3, 8'h00);
    chk("old bit", resp_r.bit_val, 1'h0);
    acc(1'h0, dsd_pkg::DSD_IO_BIT_TEST, 16'h001C, dsd_pkg::DSD_PTR_X, 6'h00, 3'h3, 8'h00);
    chk("test bit", resp_r.bit_val, 1'h1);
    rd(16'h003C, 8'h08, 1);
    acc(1'h1, dsd_pkg::DSD_IO_BIT_CLR, 16'h001C, dsd_pkg::DSD_PTR_X, 6'h00, 3'h3, 8'h00);
    rd(16'h003C, 8'h00, 1);
    acc(1'h1, dsd_pkg::DSD_IO_BIT_SET, 16'h0005, dsd_pkg::DSD_PTR_X, 6'h00, 3'h7, 8'h00);
    chk("periph set lat", lat, 3);
    rd(16'h0025, 8'hFF, 2);
    acc(1'h1, dsd_pkg::DSD_IO_BIT_SET, 16'h0020, dsd_pkg::DSD_PTR_X, 6'h00, 3'h0, 8'h00);
    chk("high bit err", resp_r.err, 1'h1);
  endtask

  // Displacement, pre-decrement and post-increment through the pointer pairs.
  task automatic t_ptr();
    wr(16'h001C, 8'h00);
    wr(16'h001D, 8'h01);
    acc(1'h1, dsd_pkg::DSD_DISPLACED, 16'h0000, dsd_pkg::DSD_PTR_Y, 6'h3F, 3'h0, 8'h5C);
    rd(16'h013F, 8'h5C, 2);
    acc(1'h1, dsd_pkg::DSD_DISPLACED, 16'h0000, dsd_pkg::DSD_PTR_X, 6'h01, 3'h0, 8'h00);
    chk("x disp err", resp_r.err, 1'h1);
    acc(1'h0, dsd_pkg::DSD_INDIRECT, 16'h0000, dsd_pkg::DSD_PTR_Y, 6'h00, 3'h0, 8'h00);
    chk("indirect", resp_r.rdata, 8'h11);
    wr(16'h001E, 8'h00);
    wr(16'h001F, 8'h02);
    acc(1'h1, dsd_pkg::DSD_POSTINC, 16'h0000, dsd_pkg::DSD_PTR_Z, 6'h00, 3'h0, 8'hAA);
    rd(16'h0200, 8'hAA, 2);
    rd(16'h001E, 8'h01, 1);
    wr(16'h001A, 8'h10);
    wr(16'h001B, 8'h00);
    acc(1'h1, dsd_pkg::DSD_PREDEC, 16'h0000, dsd_pkg::DSD_PTR_X, 6'h00, 3'h0, 8'h77);
    rd(16'h000F, 8'h77, 1);
    rd(16'h001A, 8'h0F, 1);
  endtask

  // ----------------------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand edges.
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    tally_and_finish();
  end

  // Software here writes one unmapped place, 0x0300, in t_regions.
  initial begin
    rst = 1'h1;
    req = '0;
    fetch_ip = 12'h000;
    prog_we = 1'h0;
    prog_waddr = 12'h000;
    prog_wdata = 16'h0000;
    n_mismatch = 0;
    num_checks = 0;
    repeat (5) @(posedge clk_sys);
    #1 chk("reset busy", busy_r, 1'h0);
    chk("reset resp", resp_r, '0);
    chk("reset io", io_r, '0);
    @(posedge clk_sys);
    rst <= 1'h0;
    t_prog();
    t_regions();
    t_io();
    t_bits();
    t_ptr();
    tally_and_finish();
  end
endmodule // dsd_data_space_decoder_bench
